// ==== src/potw_pkg.sv ====
// Shared constants for the wiper serial slave and its controlling master.
// Assumes one 50 MHz pclk and an open-drain two-wire bus resolved in potw_if.
//
// Contract
// - Wiper held in a 7-bit volatile register
// - Higher value moves tap toward high_terminal
// - Wiper presets to 40h at power-up
// - Device is slave; master clocks every transfer
// - Bytes shift most significant bit first
// - Data changes only while clock low
// - Data pin released after power-up
// - Ignore traffic until a START is seen
// - START ignored during power-up sequence
// - Master ends every operation with STOP
// - Receiver pulls data low on ninth clock
// - Device acks identification, address, write data
// - Master acks read bytes it still wants
// - Upper seven bits address, bit zero direction
// - Write: START, three bytes, STOP
// - Write data shifted in bit by bit
// - Address zero loads wiper at last fall
// - No ack for bad address or slave id
// - Read: write id, address, restart, read id
// - Device keeps sending while master acks
// - Master ends read with STOP
package potw_pkg;
   // Bus framing
   localparam logic [6:0] SLAVE_ADDR = 7'h2a; // Arbitrary identity value
   localparam logic [7:0] WIPER_ADDR = 8'h00;
   localparam logic [6:0] WIPER_RESET = 7'h40;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Timing
   localparam int CLK_NS = 20;
   localparam int PWRUP_NS = 1000;
   localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int QTR_NS = 2500;
   localparam int QTR_CYC = QTR_NS / CLK_NS;
   // Master register map (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] RDATA_OFS = 8'h08;
   localparam int CTRL_GO = 0;
   localparam int CTRL_RW = 1;
   localparam int CTRL_WD_LO = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_NACK = 2;
   // Master operation kinds
   typedef enum logic [1:0] {K_START, K_BYTE, K_RECV, K_STOP} potw_kind_t;
endpackage

// ==== src/potw_if.sv ====
// Two-wire bus between the wiper slave and its master.
// Open drain: a line is low whenever any party enables a low drive.
`timescale 1ns/1ps
interface potw_if;
   logic scl_out;
   logic scl_oe;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_s_out;
   logic sda_s_oe;
   logic scl_in;
   logic sda_in;

   // Wired-and with pull-ups
   assign scl_in = ~(scl_oe & ~scl_out);
   assign sda_in = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));

   modport dev (input scl_in, input sda_in, output sda_s_out, output sda_s_oe);
   modport ctl (input sda_in, output scl_out, output scl_oe, output sda_m_out, output sda_m_oe);
endinterface

// ==== src/potw_sync.sv ====
// Two-flop synchroniser for bus lines sampled by pclk.
// Assumes idle-high lines; resets to all ones.
`timescale 1ns/1ps
module potw_sync #(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   initial begin
      if (WIDTH < 1) $error("potw_sync: WIDTH must be positive");
   end

   // Two stages, first read only by second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '1;
         q <= '1;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // potw_sync

// ==== src/potw_slave.sv ====
// Wiper serial slave: holds the 7-bit wiper position behind a two-wire bus.
// Assumes presetn is the power-up reset and the master drives the clock line.
//
// The APB slave port of potw_master is this design's own decision; this slave has none.
`timescale 1ns/1ps
module potw_slave #(
   parameter int PWRUP_CYC = potw_pkg::PWRUP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   potw_if.dev bus,
   output logic [6:0] wiper_position
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum {S_IDLE, S_ID, S_ADDR, S_DATA, S_ACK, S_TX, S_TXACK} potw_sstate_t;

   potw_sstate_t state_reg, state_next;
   potw_sstate_t after_reg, after_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   logic oe_reg, oe_next;
   logic addr_ok_reg, addr_ok_next;
   logic mack_reg, mack_next;
   logic [6:0] wiper_next;
   logic [15:0] pwr_cnt_reg;
   logic ready_reg;
   logic scl_s, sda_s, scl_p, sda_p;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   logic byte_done, id_match;

   initial begin
      if (PWRUP_CYC < 1 || PWRUP_CYC > 65535) $error("potw_slave: PWRUP_CYC out of range");
   end

   // ----------------------------------------
   // Line sampling and bus events
   // ----------------------------------------
   potw_sync #(.WIDTH(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({bus.scl_in, bus.sda_in}),
      .q({scl_s, sda_s})
   );

   // Previous samples for edge finding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_p <= scl_s;
         sda_p <= sda_s;
      end
   end

   // Edges and framing conditions
   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
   assign byte_done = scl_fall && (cnt_reg == potw_pkg::BYTE_BITS);
   assign id_match = (sh_reg[7:1] == potw_pkg::SLAVE_ADDR);

   // ----------------------------------------
   // Power-up sequence
   // ----------------------------------------
   // Hold off STARTs until done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_cnt_reg <= 16'h0000;
         ready_reg <= 1'b0;
      end else if (!ready_reg) begin
         pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
         ready_reg <= (pwr_cnt_reg == 16'(PWRUP_CYC - 1));
      end
   end

   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   // Next state, shift data, line drive and wiper update
   always_comb begin
      state_next = state_reg;
      after_next = after_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      oe_next = oe_reg;
      addr_ok_next = addr_ok_reg;
      mack_next = mack_reg;
      wiper_next = wiper_position;
      if (stop_ev) begin
         state_next = S_IDLE;
         oe_next = 1'b0;
         addr_ok_next = 1'b0;
      end else if (start_ev && ready_reg) begin
         // Repeated START keeps address state
         state_next = S_ID;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end else begin
         case (state_reg)
            S_ID, S_ADDR, S_DATA: begin
               if (scl_rise && cnt_reg != potw_pkg::BYTE_BITS) begin
                  sh_next = {sh_reg[6:0], sda_s};
                  cnt_next = cnt_reg + 4'h1;
               end else if (byte_done) begin
                  cnt_next = 4'h0;
                  state_next = S_IDLE;
                  case (state_reg)
                     S_ID: begin
                        if (id_match && (!sh_reg[0] || addr_ok_reg)) begin
                           oe_next = 1'b1;
                           state_next = S_ACK;
                           after_next = sh_reg[0] ? S_TX : S_ADDR;
                        end
                     end
                     S_ADDR: begin
                        if (sh_reg == potw_pkg::WIPER_ADDR) begin
                           oe_next = 1'b1;
                           state_next = S_ACK;
                           after_next = S_DATA;
                           addr_ok_next = 1'b1;
                        end
                     end
                     default: begin
                        wiper_next = sh_reg[6:0];
                        oe_next = 1'b1;
                        state_next = S_ACK;
                        after_next = S_IDLE;
                     end
                  endcase
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  oe_next = 1'b0;
                  cnt_next = 4'h0;
                  state_next = after_reg;
                  if (after_reg == S_TX) begin
                     sh_next = {1'b0, wiper_position};
                     oe_next = 1'b1;
                  end
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (cnt_reg == potw_pkg::BYTE_BITS - 4'h1) begin
                     oe_next = 1'b0;
                     cnt_next = 4'h0;
                     state_next = S_TXACK;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     oe_next = ~sh_reg[6];
                     cnt_next = cnt_reg + 4'h1;
                  end
               end
            end
            S_TXACK: begin
               if (scl_rise) begin
                  mack_next = ~sda_s;
               end else if (scl_fall) begin
                  if (mack_reg) begin
                     sh_next = {1'b0, wiper_position};
                     oe_next = 1'b1;
                     state_next = S_TX;
                  end else begin
                     state_next = S_IDLE;
                  end
               end
            end
            default: begin
               state_next = S_IDLE;
            end
         endcase
      end
   end

   // State and counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         after_reg <= S_IDLE;
         cnt_reg <= 4'h0;
         addr_ok_reg <= 1'b0;
         mack_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         cnt_reg <= cnt_next;
         addr_ok_reg <= addr_ok_next;
         mack_reg <= mack_next;
      end
   end

   // Shift register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg <= 8'h00;
      end else begin
         sh_reg <= sh_next;
      end
   end

   // Data line drive (low when enabled)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= oe_next;
      end
   end

   // Wiper position; higher code is nearer high_terminal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wiper_position <= potw_pkg::WIPER_RESET;
      end else begin
         wiper_position <= wiper_next;
      end
   end

   // ----------------------------------------
   // Bus outputs
   // ----------------------------------------
   // Slave only: data line, never clock
   assign bus.sda_s_oe = oe_reg;
   assign bus.sda_s_out = 1'b0;
endmodule // potw_slave

// ==== src/potw_master.sv ====
// Bus master that writes or reads the wiper, ordered over APB.
// Assumes one slave on the bus and zero-wait APB access from software.
`timescale 1ns/1ps
module potw_master #(
   parameter int QTR_CYC = potw_pkg::QTR_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   potw_if.ctl bus
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum {H_IDLE, H_START, H_BIT, H_STOP} potw_hstate_t;

   potw_hstate_t st_reg;
   logic [15:0] tcnt_reg;
   logic [1:0] q_reg;
   logic [2:0] step_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg, wdata_reg, rdata_reg;
   logic rw_reg, recv_reg, busy_reg, done_reg, nack_reg;
   logic scl_oe_reg, sda_oe_reg;
   logic sda_s, tick, go, wr_en, rd_setup, op_end;
   logic [9:0] nxt_op;

   initial begin
      if (QTR_CYC < 2 || QTR_CYC > 65535) $error("potw_master: QTR_CYC out of range");
   end

   // Operation list: kind and byte for each step
   // Write and read sequences
   function automatic logic [9:0] op_of(input logic [2:0] s, input logic rd, input logic [7:0] wd);
      logic [7:0] idw;
      idw = {potw_pkg::SLAVE_ADDR, 1'b0};
      case (s)
         3'h0: op_of = {potw_pkg::K_START, 8'h00};
         3'h1: op_of = {potw_pkg::K_BYTE, idw};
         3'h2: op_of = {potw_pkg::K_BYTE, potw_pkg::WIPER_ADDR};
         3'h3: op_of = rd ? {potw_pkg::K_START, 8'h00} : {potw_pkg::K_BYTE, wd};
         3'h4: op_of = rd ? {potw_pkg::K_BYTE, potw_pkg::SLAVE_ADDR, 1'b1} : {potw_pkg::K_STOP, 8'h00};
         3'h5: op_of = {potw_pkg::K_RECV, 8'h00};
         default: op_of = {potw_pkg::K_STOP, 8'h00};
      endcase
   endfunction

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign go = wr_en && (paddr == potw_pkg::CTRL_OFS) && pwdata[potw_pkg::CTRL_GO] && !busy_reg;

   // One wait-free access phase, read data captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr != potw_pkg::CTRL_OFS)
            & (paddr != potw_pkg::STAT_OFS) & (paddr != potw_pkg::RDATA_OFS);
         if (rd_setup) begin
            if (paddr == potw_pkg::CTRL_OFS) begin
               prdata <= {16'h0000, wdata_reg, 6'h00, rw_reg, 1'b0};
            end else if (paddr == potw_pkg::STAT_OFS) begin
               prdata <= {29'h0000_0000, nack_reg, done_reg, busy_reg};
            end else if (paddr == potw_pkg::RDATA_OFS) begin
               prdata <= {24'h00_0000, rdata_reg};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end

   // Command fields, ignored while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rw_reg <= 1'b0;
         wdata_reg <= 8'h00;
      end else if (go) begin
         rw_reg <= pwdata[potw_pkg::CTRL_RW];
         wdata_reg <= pwdata[potw_pkg::CTRL_WD_LO +: 8];
      end
   end

   // ----------------------------------------
   // Bus engine
   // ----------------------------------------
   potw_sync #(.WIDTH(1)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(bus.sda_in),
      .q(sda_s)
   );

   // Quarter-bit enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcnt_reg <= 16'h0000;
      end else if (!busy_reg || tick) begin
         tcnt_reg <= 16'h0000;
      end else begin
         tcnt_reg <= tcnt_reg + 16'h0001;
      end
   end
   assign tick = busy_reg && (tcnt_reg == 16'(QTR_CYC - 1));
   assign op_end = tick && (q_reg == 2'h3);
   assign nxt_op = op_of(step_reg + 3'h1, rw_reg, wdata_reg);

   // Master makes the clock and sequences
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= H_IDLE;
         q_reg <= 2'h0;
         step_reg <= 3'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         recv_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         nack_reg <= 1'b0;
         rdata_reg <= 8'h00;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (go) begin
         st_reg <= H_START;
         q_reg <= 2'h0;
         step_reg <= 3'h0;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else if (tick) begin
         q_reg <= q_reg + 2'h1;
         case (st_reg)
            H_START: begin
               // Release, clock high, data falls, clock low
               case (q_reg)
                  2'h0: sda_oe_reg <= 1'b0;
                  2'h1: scl_oe_reg <= 1'b0;
                  2'h2: sda_oe_reg <= 1'b1;
                  default: scl_oe_reg <= 1'b1;
               endcase
            end
            H_BIT: begin
               case (q_reg)
                  // Data set while clock low, msb first
                  2'h0: sda_oe_reg <= ~recv_reg & (bit_reg != potw_pkg::BYTE_BITS) & ~sh_reg[7];
                  2'h1: scl_oe_reg <= 1'b0;
                  2'h2: begin
                     if (bit_reg != potw_pkg::BYTE_BITS) begin
                        sh_reg <= {sh_reg[6:0], sda_s};
                     end else if (!recv_reg) begin
                        nack_reg <= sda_s;
                     end
                  end
                  default: begin
                     scl_oe_reg <= 1'b1;
                     bit_reg <= bit_reg + 4'h1;
                  end
               endcase
            end
            H_STOP: begin
               case (q_reg)
                  2'h0: sda_oe_reg <= 1'b1;
                  2'h1: scl_oe_reg <= 1'b0;
                  2'h2: sda_oe_reg <= 1'b0;
                  default: begin
                     busy_reg <= 1'b0;
                     done_reg <= 1'b1;
                     st_reg <= H_IDLE;
                  end
               endcase
            end
            default: st_reg <= H_IDLE;
         endcase
         // Advance to next operation at end of a start or byte
         if (op_end && (st_reg == H_START || (st_reg == H_BIT && bit_reg == potw_pkg::BYTE_BITS))) begin
            step_reg <= step_reg + 3'h1;
            bit_reg <= 4'h0;
            sh_reg <= nxt_op[7:0];
            recv_reg <= (nxt_op[9:8] == potw_pkg::K_RECV);
            if (recv_reg) begin
               // Single byte wanted: nack then stop
               rdata_reg <= sh_reg;
            end
            if (st_reg == H_BIT && nack_reg) begin
               st_reg <= H_STOP;
            end else if (nxt_op[9:8] == potw_pkg::K_START) begin
               st_reg <= H_START;
            end else if (nxt_op[9:8] == potw_pkg::K_STOP) begin
               st_reg <= H_STOP;
            end else begin
               st_reg <= H_BIT;
            end
         end
      end
   end

   // Open-drain drives: enable pulls low
   assign bus.scl_oe = scl_oe_reg;
   assign bus.sda_m_oe = sda_oe_reg;
   assign bus.scl_out = 1'b0;
   assign bus.sda_m_out = 1'b0;
endmodule // potw_master

// ==== tb/potw_chk.sv ====
// Concurrent checks on the two-wire bus between wiper slave and master.
// Assumes the bench master runs with a quarter of 8 pclk cycles.
`timescale 1ns/1ps
module potw_chk (
   input logic pclk,
   input logic presetn,
   input logic scl_in,
   input logic sda_in,
   input logic scl_oe,
   input logic sda_m_oe,
   input logic sda_s_oe,
   input logic [6:0] wiper_position
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Bus line checks
   // ----------------------------------------
   // Slave data drive and master clock drive released while in power-up reset
   a_reset_lines_free: assert property (disable iff (1'b0) !presetn |-> !sda_s_oe && !scl_oe)
      else $error("line driven in reset");
   // Wiper midscale right after power-up
   a_wiper_pwr_mid: assert property ($rose(presetn) |-> wiper_position == 7'h40)
      else $error("wiper not midscale after reset");
   // Slave data drive only moves with clock low
   a_slave_chg_low: assert property ($changed(sda_s_oe) |-> !scl_in)
      else $error("slave data changed with clock high");
   // Wiper loads only in the low phase
   a_wiper_chg_low: assert property ($changed(wiper_position) |-> !scl_in)
      else $error("wiper changed with clock high");
   // Only the master ever holds the clock low
   a_clock_by_master: assert property (!scl_in |-> scl_oe)
      else $error("clock low without master drive");
   // Transmitter released while receiver drives in the clock high phase
   a_no_collide: assert property (scl_in |-> !(sda_s_oe && sda_m_oe))
      else $error("both parties drive data");
   // Slave drive starts shortly after a clock fall
   a_drive_timing: assert property ($rose(sda_s_oe) |-> $past(scl_in, 6) && !scl_in)
      else $error("slave drive not after clock fall");
   // Slave drive never outlasts one byte and its ack
   a_drive_bounded: assert property ($rose(sda_s_oe) |-> ##[1:320] !sda_s_oe)
      else $error("slave holds data line too long");
endmodule // potw_chk

// ==== tb/pot_wiper_i2c_slave_tb_top.sv ====
// Testbench: APB orders to the master, which writes and reads the slave wiper.
// Assumes the master and slave are joined by potw_if and nothing else on the bus.
`timescale 1ns/1ps
module pot_wiper_i2c_slave_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [6:0] wiper_position;
   logic scl_d = 1'b1;
   logic [39:0] log_bits = 40'h0;
   logic [31:0] rd;
   logic er;
   logic [7:0] d;
   int err_count = 0;
   int checks = 0;
   potw_if bus ();
   potw_slave #(.PWRUP_CYC(2)) i_potw_slave (.pclk(pclk), .presetn(presetn), .bus(bus),
      .wiper_position(wiper_position));
   potw_master #(.QTR_CYC(8)) i_potw_master (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(bus));
   potw_chk i_potw_chk (.pclk(pclk), .presetn(presetn), .scl_in(bus.scl_in),
      .sda_in(bus.sda_in), .scl_oe(bus.scl_oe), .sda_m_oe(bus.sda_m_oe),
      .sda_s_oe(bus.sda_s_oe), .wiper_position(wiper_position));
   // ----------------------------------------
   // Clock and wire monitor
   // ----------------------------------------
   // 50 MHz clock
   initial begin
      forever #10 pclk = ~pclk;
   end
   // Data bit shifted in at every clock rise
   always @(posedge pclk) begin
      scl_d <= bus.scl_in;
      if (bus.scl_in && !scl_d) begin
         log_bits <= {log_bits[38:0], bus.sda_in};
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One APB transfer; answer taken at the edge where pready is high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Sample pready, prdata and pslverr at the rising edge that completes the access
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         err_count++;
         print_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Start an operation, then poll until not busy
   task automatic run(input logic rw, input logic [7:0] wd, input logic twice);
      int n;
      apb(1'b1, potw_pkg::CTRL_OFS, {16'h0, wd, 6'h0, rw, 1'b1}, rd, er);
      if (twice) apb(1'b1, potw_pkg::CTRL_OFS, {16'h0, ~wd, 6'h0, rw, 1'b1}, rd, er);
      for (n = 0; n < 2000; n++) begin
         apb(1'b0, potw_pkg::STAT_OFS, 32'h0, rd, er);
         if (rd[potw_pkg::STAT_BUSY] === 1'b0) break;
      end
      if (n == 2000) begin
         err_count++;
         print_verdict();
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (60) @(posedge pclk);
      // Power-up preset of the wiper
      chk("wiper_reset", wiper_position, 40'h40);
      apb(1'b0, 8'h0c, 32'h0, rd, er);
      chk("unmapped_err", er, 40'h1);
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'hc5;
         run(1'b0, d, 1'b0);
         chk("wr_status", rd[2:0], 40'h2);
         // Id, ack, address, ack, data, ack, then the STOP clock rise
         chk("wr_wire", log_bits[27:0], {potw_pkg::SLAVE_ADDR, 2'h0, 8'h0, 1'b0, d, 2'h0});
         chk("wiper_after_wr", wiper_position, d[6:0]);
         run(1'b1, 8'h00, 1'b0);
         chk("rd_status", rd[2:0], 40'h2);
         // Restart rise, read id, ack, zero top bit, data, nack, STOP rise
         chk("rd_wire", log_bits[19:0], {1'b1, potw_pkg::SLAVE_ADDR, 3'h4, d[6:0], 2'h2});
         apb(1'b0, potw_pkg::RDATA_OFS, 32'h0, rd, er);
         chk("rd_data", rd, {25'h0, d[6:0]});
      end
      // Second order while busy is dropped
      run(1'b0, 8'h11, 1'b1);
      chk("busy_refused", wiper_position, 40'h11);
      print_verdict();
   end
endmodule // pot_wiper_i2c_slave_tb_top
